/* src/udes_core.sv */
/*
  Endpoint configuration, buffer allocation, endpoint events and commands, suspend and wake-up control.
  Assumes the serial interface engine on the same clock reports packets as one-cycle pulses,
  and that bus pins, wake pin, chip select and VBUS arrive asynchronously.
*/
`timescale 1ns/10ps
`default_nettype none
module udes_core #(
  parameter int IDLE_CYC = udes_pkg::IDLE_CYCLES,
  parameter int CLKSTOP_CYC = udes_pkg::CLKSTOP_CYCLES,
  parameter int SETTLE_CYC = udes_pkg::SETTLE_CYCLES,
  parameter int KDRIVE_CYC = udes_pkg::KDRIVE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Serial interface engine events
  input wire logic PKT_DONE,
  input wire logic [3:0] PKT_EP,
  input wire logic PKT_SETUP,
  input wire logic USB_BUS_RESET,
  // Asynchronous pins
  input wire logic BUS_IDLE,
  input wire logic BUS_K,
  input wire logic WAKEUP,
  input wire logic CS_N,
  input wire logic VBUS,
  // Status outputs
  output logic [15:0] EP_READY,
  output logic INT,
  output logic SUSPEND,
  output logic CLOCKS_ON,
  output logic DRIVE_K
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic idle_s, k_s, wake_s, cs_n_s, vbus_s;
  udes_pkg::udes_ecr_t ecr_q [udes_pkg::NUM_EP];
  logic [15:0] ev_q, full_q;
  logic [31:0] flag_q, mask_q, hwcfg_q;
  logic go_suspend_bit_q, setup_lock_q, locked_q, bus_susp_q;
  logic [31:0] idle_cnt_q, pwr_cnt_q;
  udes_pkg::udes_pwr_t pwr_q;
  logic [11:0] alloc_d, alloc_q;
  logic acc, wr_acc, rd_acc, wr_ok;
  logic [31:0] rdata_d;
  logic [3:0] cmd_ep;
  logic [3:0] cmd_code;
  logic esr_rd;
  logic [3:0] esr_ep;
  logic wake_req, remote_req;

  // Physical bytes of one endpoint
  function automatic logic [11:0] ep_bytes(input udes_pkg::udes_ecr_t e);
    logic [10:0] b;
    b = 11'h000;
    if (e.isochronous_select_bit) begin
      b = udes_pkg::ISO_BYTES[e.buffer_size_code];
    end else begin
      case (e.buffer_size_code)
        4'h0: b = 11'h008;
        4'h1: b = 11'h010;
        4'h2: b = 11'h020;
        4'h3: b = 11'h040;
        default: b = 11'h000;
      endcase
    end //RQ1
    if (!e.endpoint_enable_bit) begin
      b = 11'h000; //RQ2
    end
    return e.dbl ? {b, 1'b0} : {1'b0, b}; //RQ5
  endfunction

  // Reset release
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pin synchronisers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 5'h08;
      pin_s2_q <= 5'h08;
    end else begin
      pin_s1_q <= {VBUS, CS_N, WAKEUP, BUS_K, BUS_IDLE};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign idle_s = pin_s2_q[0];
  assign k_s = pin_s2_q[1];
  assign wake_s = pin_s2_q[2];
  assign cs_n_s = pin_s2_q[3];
  assign vbus_s = pin_s2_q[4];

  // Bus handshake: one wait cycle, then the request is taken
  assign acc = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign wr_acc = acc & AVS_WRITE;
  assign rd_acc = acc & AVS_READ;
  assign wr_ok = wr_acc & ~locked_q; //RQ22
  assign cmd_ep = AVS_WRITEDATA[11:8];
  assign cmd_code = AVS_WRITEDATA[3:0];
  assign esr_rd = rd_acc & (AVS_ADDRESS[7:6] == udes_pkg::ESR_BASE[7:6]);
  assign esr_ep = AVS_ADDRESS[5:2];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (AVS_ADDRESS[7:6] == udes_pkg::ECR_BASE[7:6]) begin
      rdata_d = {24'h00_0000, ecr_q[AVS_ADDRESS[5:2]]};
    end else if (AVS_ADDRESS[7:6] == udes_pkg::ESR_BASE[7:6]) begin
      rdata_d = {29'h0, ev_q[AVS_ADDRESS[5:2]], setup_lock_q, full_q[AVS_ADDRESS[5:2]]}; //RQ9
    end else begin
      case (AVS_ADDRESS)
        udes_pkg::ALLOC_OFS: rdata_d = {20'h0_0000, alloc_q}; //RQ4
        udes_pkg::IFLAG_OFS: rdata_d = flag_q | {12'h000, locked_q, bus_susp_q, 2'h0, ev_q}; //RQ15
        udes_pkg::IMASK_OFS: rdata_d = mask_q;
        udes_pkg::HWCFG_OFS: rdata_d = hwcfg_q;
        udes_pkg::MODE_OFS: rdata_d = {31'h0, go_suspend_bit_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      AVS_READDATA <= rdata_d;
    end
  end

  // Endpoint configuration
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < udes_pkg::NUM_EP; i++) begin
        ecr_q[i] <= '0;
      end
    end else if (USB_BUS_RESET) begin
      for (int i = 0; i < udes_pkg::NUM_EP; i++) begin
        ecr_q[i] <= '0; //RQ8
      end
    end else if (wr_ok && AVS_ADDRESS[7:6] == udes_pkg::ECR_BASE[7:6] && AVS_ADDRESS[5:2] > 4'h1) begin
      ecr_q[AVS_ADDRESS[5:2]] <= AVS_WRITEDATA[7:0]; //RQ6
    end
  end

  // Allocation follows the configuration without software help
  always_comb begin
    alloc_d = {1'b0, udes_pkg::CTRL_BYTES} + {1'b0, udes_pkg::CTRL_BYTES}; //RQ8
    for (int i = 2; i < udes_pkg::NUM_EP; i++) begin
      alloc_d = alloc_d + ep_bytes(ecr_q[i]); //RQ6
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      alloc_q <= 12'h080;
    end else begin
      alloc_q <= alloc_d; //RQ2
    end
  end

  // Endpoint events, set wins over the status-read clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= 16'h0000;
    end else begin
      for (int i = 0; i < udes_pkg::NUM_EP; i++) begin
        if ((PKT_DONE || PKT_SETUP) && PKT_EP == i[3:0]) begin
          ev_q[i] <= 1'b1; //RQ9
        end else if (esr_rd && esr_ep == i[3:0]) begin
          ev_q[i] <= 1'b0; //RQ9
        end
      end
    end
  end

  // Buffer state and control-endpoint lock
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= 16'h0000;
    end else if (USB_BUS_RESET) begin
      full_q <= 16'h0000;
    end else begin
      for (int i = 0; i < udes_pkg::NUM_EP; i++) begin
        if (PKT_SETUP && i == 1) begin
          full_q[i] <= 1'b0; //RQ12
        end else if ((PKT_DONE || PKT_SETUP) && PKT_EP == i[3:0]) begin
          full_q[i] <= ~(i == 1 || ecr_q[i].dir_in); //RQ10
        end else if (wr_ok && AVS_ADDRESS == udes_pkg::CMD_OFS && cmd_ep == i[3:0] &&
                     !(setup_lock_q && i < 2)) begin //RQ12
          if (cmd_code == udes_pkg::CMD_VALIDATE) begin
            full_q[i] <= 1'b1; //RQ11
          end else if (cmd_code == udes_pkg::CMD_CLEAR) begin
            full_q[i] <= 1'b0; //RQ10
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      setup_lock_q <= 1'b0;
    end else if (PKT_SETUP) begin
      setup_lock_q <= 1'b1; //RQ12
    end else if (wr_ok && AVS_ADDRESS == udes_pkg::CMD_OFS && cmd_code == udes_pkg::CMD_ACKSETUP) begin
      setup_lock_q <= 1'b0; //RQ12
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      EP_READY <= 16'h0001;
    end else begin
      for (int i = 0; i < udes_pkg::NUM_EP; i++) begin
        EP_READY[i] <= (i < 2 || ecr_q[i].endpoint_enable_bit) &&
                       ((i == 1 || ecr_q[i].dir_in) ? full_q[i] : ~full_q[i]); //RQ10 RQ11
      end
    end
  end

  // Software controls
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 32'h0000_0000;
      hwcfg_q <= udes_pkg::HWCFG_RESET;
      go_suspend_bit_q <= 1'b0;
    end else if (wr_ok) begin
      if (AVS_ADDRESS == udes_pkg::IMASK_OFS) begin
        mask_q <= AVS_WRITEDATA;
      end
      if (AVS_ADDRESS == udes_pkg::HWCFG_OFS) begin
        hwcfg_q <= {29'h0, AVS_WRITEDATA[2:0]};
      end
      if (AVS_ADDRESS == udes_pkg::MODE_OFS) begin
        go_suspend_bit_q <= AVS_WRITEDATA[0];
      end
    end
  end

  // Write lock after wake
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
    end else if (pwr_q == udes_pkg::UDES_SETTLE && pwr_cnt_q + 32'd1 >= 32'(SETTLE_CYC)) begin
      locked_q <= 1'b1; //RQ22
    end else if (wr_acc && AVS_ADDRESS == udes_pkg::UNLOCK_OFS && AVS_WRITEDATA[15:0] == udes_pkg::UNLOCK_KEY) begin
      locked_q <= 1'b0; //RQ23
    end
  end

  // Idle detection
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 32'h0;
      bus_susp_q <= 1'b0;
    end else if (!idle_s) begin
      idle_cnt_q <= 32'h0;
      bus_susp_q <= 1'b0; //RQ15
    end else if (idle_cnt_q < 32'(IDLE_CYC)) begin
      idle_cnt_q <= idle_cnt_q + 32'd1; //RQ24
    end else begin
      bus_susp_q <= 1'b1; //RQ13
    end
  end

  assign wake_req = k_s | wake_s | remote_req; //RQ18
  assign remote_req = ~cs_n_s & hwcfg_q[udes_pkg::WKCS_BIT] & vbus_s; //RQ18

  // Power sequencer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= udes_pkg::UDES_AWAKE;
      pwr_cnt_q <= 32'h0;
    end else begin
      pwr_cnt_q <= pwr_cnt_q + 32'd1; //RQ24
      case (pwr_q)
        udes_pkg::UDES_AWAKE: begin
          pwr_cnt_q <= 32'h0;
          if (wr_ok && AVS_ADDRESS == udes_pkg::MODE_OFS && go_suspend_bit_q && !AVS_WRITEDATA[0]) begin
            pwr_q <= hwcfg_q[udes_pkg::PWROFF_BIT] ? udes_pkg::UDES_SUSP_WAIT : udes_pkg::UDES_SUSPENDED; //RQ17
          end
        end
        udes_pkg::UDES_SUSP_WAIT: begin
          if (pwr_cnt_q + 32'd1 >= 32'(CLKSTOP_CYC)) begin
            pwr_q <= udes_pkg::UDES_SUSPENDED; //RQ17
          end
        end
        udes_pkg::UDES_SUSPENDED: begin
          pwr_cnt_q <= 32'h0;
          if (wake_req) begin
            pwr_q <= udes_pkg::UDES_SETTLE; //RQ18
          end
        end
        udes_pkg::UDES_SETTLE: begin
          if (pwr_cnt_q + 32'd1 >= 32'(SETTLE_CYC)) begin
            pwr_cnt_q <= 32'h0;
            pwr_q <= (wake_s | remote_req) ? udes_pkg::UDES_KDRIVE : udes_pkg::UDES_AWAKE; //RQ19 RQ20
          end
        end
        udes_pkg::UDES_KDRIVE: begin
          if (pwr_cnt_q + 32'd1 >= 32'(KDRIVE_CYC)) begin
            pwr_q <= udes_pkg::UDES_AWAKE; //RQ21
          end
        end
        default: pwr_q <= udes_pkg::UDES_AWAKE;
      endcase
    end
  end

  // Suspend and resume flags, set wins over write-one clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 32'h0;
    end else begin
      if (idle_s && idle_cnt_q == 32'(IDLE_CYC) && !bus_susp_q) begin
        flag_q[udes_pkg::SUSP_BIT] <= 1'b1; //RQ14
      end else if (wr_ok && AVS_ADDRESS == udes_pkg::IFLAG_OFS && AVS_WRITEDATA[udes_pkg::SUSP_BIT]) begin
        flag_q[udes_pkg::SUSP_BIT] <= 1'b0;
      end
      if (pwr_q == udes_pkg::UDES_SETTLE && pwr_cnt_q + 32'd1 >= 32'(SETTLE_CYC)) begin
        flag_q[udes_pkg::RESM_BIT] <= 1'b1; //RQ19
      end else if (wr_ok && AVS_ADDRESS == udes_pkg::IFLAG_OFS && AVS_WRITEDATA[udes_pkg::RESM_BIT]) begin
        flag_q[udes_pkg::RESM_BIT] <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      INT <= 1'b0;
      SUSPEND <= 1'b0;
      CLOCKS_ON <= 1'b1;
      DRIVE_K <= 1'b0;
    end else begin
      INT <= |((flag_q | {16'h0000, ev_q}) & mask_q); //RQ14 RQ19
      SUSPEND <= (pwr_q == udes_pkg::UDES_SUSPENDED) || (pwr_q == udes_pkg::UDES_SETTLE); //RQ17 RQ19
      CLOCKS_ON <= hwcfg_q[udes_pkg::CLOCK_RUN_BIT_BIT] && pwr_q != udes_pkg::UDES_SUSPENDED; //RQ16
      DRIVE_K <= (pwr_q == udes_pkg::UDES_KDRIVE); //RQ21
    end
  end
endmodule
`default_nettype wire

/* src/udes_pkg.sv */
/*
  Constants, register map and carrier types of the USB device endpoint and suspend core.
  Assumes a 20 MHz core clock and an Avalon-MM register slave with 32-bit words.
*/
// Contract
// [RQ1] Size code selects endpoint buffer capacity
// [RQ2] Only enabled endpoints receive buffer storage
// [RQ3] Software keeps allocation fixed while data held
// [RQ4] Software keeps total storage within 2462 bytes
// [RQ5] Double buffering reserves twice the packet size
// [RQ6] Software writes all sixteen configurations; hardware allocates (the core ignores writes to endpoints 0 and 1)
// [RQ7] Software answers configuration with empty packet
// [RQ8] Reset clears configurations; control endpoint stays enabled
// [RQ9] Packet sets event bit; status read clears
// [RQ10] Receive buffer reopens only after clear command
// [RQ11] Transmit buffer sent only after validate command
// [RQ12] SETUP flushes control IN, locks commands
// [RQ13] Suspend seen after more than 3 ms idle
// [RQ14] Suspend flag set; interrupt gated by enable
// [RQ15] Live bus state bit reads one when suspended
// [RQ16] Clearing clock run bit stops internal clocks
// [RQ17] Go-suspend high then low enters suspend
// [RQ18] Wake on K-state, wake pin, select low
// [RQ19] Wake restarts clocks, drops suspend, sets resume
// [RQ20] Normal operation within 15 ms of wake
// [RQ21] Remote wake drives K-state for 10 ms
// [RQ22] Register writes locked after any wake
// [RQ23] Only value AA37 unlocks register writes
// [RQ24] Durations counted on internal clock by parameters
package udes_pkg;
  localparam int NUM_EP = 16;
  localparam int CLK_KHZ = 20000;
  // Durations as printed, in microseconds
  localparam int IDLE_US = 3000;
  localparam int CLKSTOP_US = 2000;
  localparam int WAKE_MAX_US = 15000;
  localparam int SETTLE_US = 2000;
  localparam int KDRIVE_US = 10000;
  localparam int IDLE_CYCLES = (IDLE_US * CLK_KHZ) / 1000;
  localparam int CLKSTOP_CYCLES = (CLKSTOP_US * CLK_KHZ) / 1000;
  localparam int SETTLE_CYCLES = (SETTLE_US * CLK_KHZ) / 1000;
  localparam int KDRIVE_CYCLES = (KDRIVE_US * CLK_KHZ) / 1000;
  localparam int WAKE_MAX_CYCLES = (WAKE_MAX_US * CLK_KHZ) / 1000;
  // Byte addresses
  localparam logic [7:0] ECR_BASE = 8'h00;
  localparam logic [7:0] ALLOC_OFS = 8'h40;
  localparam logic [7:0] IFLAG_OFS = 8'h44;
  localparam logic [7:0] IMASK_OFS = 8'h48;
  localparam logic [7:0] HWCFG_OFS = 8'h4C;
  localparam logic [7:0] MODE_OFS = 8'h50;
  localparam logic [7:0] CMD_OFS = 8'h54;
  localparam logic [7:0] UNLOCK_OFS = 8'h58;
  localparam logic [7:0] ESR_BASE = 8'h80;
  // Interrupt flag and mask bit positions
  localparam int SUSP_BIT = 16;
  localparam int RESM_BIT = 17;
  localparam int BUSST_BIT = 18;
  localparam int LOCK_BIT = 19;
  // Hardware configuration bits
  localparam int CLOCK_RUN_BIT_BIT = 0;
  localparam int WKCS_BIT = 1;
  localparam int PWROFF_BIT = 2;
  localparam logic [31:0] HWCFG_RESET = 32'h0000_0001;
  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;
  localparam logic [10:0] CTRL_BYTES = 11'h040;
  // Isochronous buffer bytes by size code
  localparam logic [10:0] ISO_BYTES [16] = '{11'h010, 11'h020, 11'h030, 11'h040, 11'h060, 11'h080, 11'h0A0,
    11'h0C0, 11'h100, 11'h140, 11'h180, 11'h200, 11'h280, 11'h300, 11'h380, 11'h3FF};
  // Command codes in bits [3:0], endpoint in bits [11:8]
  localparam logic [3:0] CMD_VALIDATE = 4'h1;
  localparam logic [3:0] CMD_CLEAR = 4'h2;
  localparam logic [3:0] CMD_ACKSETUP = 4'h3;

  typedef struct packed {
    logic dir_in;
    logic [3:0] buffer_size_code;
    logic dbl;
    logic isochronous_select_bit;
    logic endpoint_enable_bit;
  } udes_ecr_t;

  typedef enum logic [2:0] {
    UDES_AWAKE, UDES_SUSP_WAIT, UDES_SUSPENDED, UDES_SETTLE, UDES_KDRIVE
  } udes_pwr_t;
endpackage

/* verif/udes_core_sva.sv */
/*
  Port-level checker for the endpoint and suspend core, bound into udes_core.
  Assumes one clock domain and the small duration parameters the bench uses.
*/
`timescale 1ns/10ps
`default_nettype none
module udes_core_chk #(
  parameter int SETTLE_CYC = 10,
  parameter int KDRIVE_CYC = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Bus events and pins
  input wire logic PKT_DONE,
  input wire logic [3:0] PKT_EP,
  input wire logic PKT_SETUP,
  input wire logic USB_BUS_RESET,
  input wire logic BUS_K,
  input wire logic WAKEUP,
  // Status
  input wire logic [15:0] EP_READY,
  input wire logic SUSPEND,
  input wire logic DRIVE_K
);
  localparam int WAKE_LIM = SETTLE_CYC + 8;
  logic [31:0] k_cnt_q;
  logic [3:0] ep_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Length of the current K drive
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) k_cnt_q <= '0;
    else k_cnt_q <= DRIVE_K ? k_cnt_q + 32'h0000_0001 : '0;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) ep_q <= 4'h0;
    else if (PKT_DONE) ep_q <= PKT_EP;
  end
  wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  rd_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h60 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  kdrive_len_a: assert property ($fell(DRIVE_K) |-> k_cnt_q == 32'(KDRIVE_CYC))
    else $error("remote wake K drive has wrong length");
  drivek_awake_a: assert property (DRIVE_K |-> !SUSPEND)
    else $error("K drive while suspend output high");
  setup_flush_a: assert property (PKT_SETUP |-> ##[1:2] EP_READY[1:0] == 2'b00)
    else $error("setup did not flush control buffers");
  pkt_event_a: assert property (PKT_DONE && !PKT_SETUP |-> ##[1:2] !EP_READY[ep_q])
    else $error("packet did not close the endpoint buffer");
  bus_reset_a: assert property ($rose(USB_BUS_RESET) |-> ##[1:2] EP_READY == 16'h0001)
    else $error("bus reset left endpoint state");
  wake_bound_a: assert property (SUSPEND && $rose(BUS_K || WAKEUP) |-> ##[1:WAKE_LIM] !SUSPEND)
    else $error("wake-up took too long");
  cover property ($rose(DRIVE_K));
  cover property ($fell(SUSPEND));
  cover property (PKT_SETUP);
endmodule
bind udes_core udes_core_chk #(.SETTLE_CYC(SETTLE_CYC), .KDRIVE_CYC(KDRIVE_CYC)) chk (.CLK(CLK), .RESETN(RESETN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PKT_DONE(PKT_DONE), .PKT_EP(PKT_EP), .PKT_SETUP(PKT_SETUP),
  .USB_BUS_RESET(USB_BUS_RESET), .BUS_K(BUS_K), .WAKEUP(WAKEUP), .EP_READY(EP_READY), .SUSPEND(SUSPEND),
  .DRIVE_K(DRIVE_K));
`default_nettype wire

/* verif/udes_host_model.sv */
/*
  Behavioural upstream host: packets, bus reset, idle and K line states.
  Assumes the bench calls its tasks one at a time on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module udes_host_model (
  // Clock and device state
  input wire logic CLK,
  input wire logic [15:0] EP_READY,
  // Packet events
  output logic PKT_DONE,
  output logic [3:0] PKT_EP,
  output logic PKT_SETUP,
  output logic USB_BUS_RESET,
  // Line state
  output logic BUS_IDLE,
  output logic BUS_K
);
  initial begin
    PKT_DONE = 1'b0;
    PKT_EP = 4'h5;
    PKT_SETUP = 1'b0;
    USB_BUS_RESET = 1'b0;
    BUS_IDLE = 1'b0;
    BUS_K = 1'b0;
  end
  // Host transfers into an open buffer, or always for SETUP; otherwise it is refused
  task automatic pkt(input logic [3:0] ep, input bit setup, output bit taken);
    @(posedge CLK);
    taken = setup || EP_READY[ep] === 1'b1;
    PKT_EP <= ep;
    PKT_SETUP <= setup;
    PKT_DONE <= taken && !setup;
    @(posedge CLK);
    PKT_DONE <= 1'b0;
    PKT_SETUP <= 1'b0;
    PKT_EP <= ~ep;
  endtask
  task automatic bus_reset();
    @(posedge CLK);
    USB_BUS_RESET <= 1'b1;
    @(posedge CLK);
    USB_BUS_RESET <= 1'b0;
  endtask
  task automatic line(input bit idle, input bit k);
    @(posedge CLK);
    BUS_IDLE <= idle;
    BUS_K <= k;
  endtask
endmodule
`default_nettype wire

/* verif/udes_core_tb.sv */
/*
  Self-checking bench for the endpoint and suspend core with shortened durations.
  Assumes the host model on the packet side and an Avalon-MM master in the bench.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module udes_core_tb;
  localparam int SCYC = 10;
  localparam int TCYC = 10;
  logic CLK = 1'b0;
  logic RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, PKT_DONE, PKT_SETUP, USB_BUS_RESET, BUS_IDLE, BUS_K;
  logic WAKEUP, CS_N, VBUS, INT, SUSPEND, CLOCKS_ON, DRIVE_K;
  logic [7:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] PKT_EP;
  logic [15:0] EP_READY;
  int bad_count, num_checks, n;
  bit tk;
  always #25 CLK = ~CLK;
  udes_core #(.IDLE_CYC(20), .CLKSTOP_CYC(SCYC), .SETTLE_CYC(TCYC), .KDRIVE_CYC(20)) dut (.CLK(CLK),
    .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PKT_DONE(PKT_DONE), .PKT_EP(PKT_EP), .PKT_SETUP(PKT_SETUP), .USB_BUS_RESET(USB_BUS_RESET),
    .BUS_IDLE(BUS_IDLE), .BUS_K(BUS_K), .WAKEUP(WAKEUP), .CS_N(CS_N), .VBUS(VBUS), .EP_READY(EP_READY),
    .INT(INT), .SUSPEND(SUSPEND), .CLOCKS_ON(CLOCKS_ON), .DRIVE_K(DRIVE_K));
  udes_host_model host (.CLK(CLK), .EP_READY(EP_READY), .PKT_DONE(PKT_DONE), .PKT_EP(PKT_EP),
    .PKT_SETUP(PKT_SETUP), .USB_BUS_RESET(USB_BUS_RESET), .BUS_IDLE(BUS_IDLE), .BUS_K(BUS_K));
  // One bus transfer; read data lands in q
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    `CHK(EP_READY, 16'h0001)
    xfer(0, 8'h0C, 32'h0);
    `CHK(q, 32'h0)
    xfer(0, 8'h4C, 32'h0);
    `CHK(q, udes_pkg::HWCFG_RESET)
    xfer(0, 8'h60, 32'h0);
    `CHK(q, 32'h0)
  endtask
  task automatic t_alloc();
    int iso [16] = '{16, 32, 48, 64, 96, 128, 160, 192, 256, 320, 384, 512, 640, 768, 896, 1023};
    // Buffers stay empty while allocation changes
    for (int c = 0; c < 16; c++) begin
      xfer(1, 8'h08, 32'h3 | (c << 3));
      xfer(1, 8'h0C, 32'h1 | (c << 3));
      xfer(0, 8'h40, 32'h0);
      `CHK(q, 32'(128 + iso[c] + (c < 4 ? 8 << c : 0)))
    end
    // All sixteen in order: IN iso double 1023, OUT 64, reserved, disabled, double 64
    for (int e = 0; e < 16; e++) begin
      xfer(1, 8'(e * 4), e == 2 ? 32'hFF : e == 3 ? 32'h19 : e == 5 ? 32'h21 :
           e == 6 ? 32'h18 : e == 7 ? 32'h1D : 32'h0);
    end
    xfer(0, 8'h40, 32'h0);
    `CHK(q, 32'd2366)
    xfer(0, 8'h0C, 32'h0);
    `CHK(q, 32'h19)
  endtask
  task automatic t_events();
    `CHK(EP_READY[3], 1'b1)
    host.pkt(4'h3, 1'b0, tk);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[3], 1'b0)
    xfer(0, 8'h44, 32'h0);
    `CHK(q[3], 1'b1)
    xfer(0, 8'h8C, 32'h0);
    `CHK(q[2:0], 3'b101)
    xfer(0, 8'h44, 32'h0);
    `CHK(q[3], 1'b0)
    xfer(1, 8'h54, 32'h0302);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[3:2], 2'b10)
    xfer(1, 8'h54, 32'h0201);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[2], 1'b1)
    host.pkt(4'h2, 1'b0, tk);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[2], 1'b0)
    host.bus_reset();
    xfer(0, 8'h40, 32'h0);
    `CHK(q, 32'd128)
  endtask
  task automatic t_setup();
    host.pkt(4'h0, 1'b1, tk);
    xfer(0, 8'h80, 32'h0);
    `CHK(q[1], 1'b1)
    xfer(1, 8'h54, 32'h0101);
    xfer(1, 8'h54, 32'h0002);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[1:0], 2'b00)
    xfer(1, 8'h54, 32'h0003);
    xfer(1, 8'h54, 32'h0101);
    xfer(1, 8'h54, 32'h0002);
    repeat (2) @(posedge CLK);
    `CHK(EP_READY[1:0], 2'b11)
  endtask
  task automatic t_suspend();
    xfer(1, 8'h48, 32'h0003_0000);
    host.line(1'b1, 1'b0);
    repeat (10) @(posedge CLK);
    `CHK(INT, 1'b0)
    repeat (40) @(posedge CLK);
    xfer(0, 8'h44, 32'h0);
    `CHK(q[18:16], 3'b101)
    `CHK(INT, 1'b1)
    xfer(1, 8'h48, 32'h0);
    repeat (3) @(posedge CLK);
    `CHK(INT, 1'b0)
    xfer(1, 8'h48, 32'h0003_0000);
    xfer(1, 8'h4C, 32'h4);
    repeat (3) @(posedge CLK);
    `CHK(CLOCKS_ON, 1'b0)
    xfer(1, 8'h50, 32'h1);
    xfer(1, 8'h50, 32'h0);
    for (n = 0; SUSPEND !== 1'b1 && n < 100; n++) @(posedge CLK);
    `CHK(n >= SCYC && n <= SCYC + 4, 1'b1)
    host.line(1'b0, 1'b1);
    for (n = 0; SUSPEND !== 1'b0 && n < 100; n++) @(posedge CLK);
    `CHK(n >= TCYC && n <= TCYC + 8, 1'b1)
    host.line(1'b0, 1'b0);
    `CHK(DRIVE_K, 1'b0)
    xfer(0, 8'h44, 32'h0);
    `CHK(q[19:17], 3'b101)
    xfer(1, 8'h48, 32'h0);
    xfer(1, 8'h58, 32'h1234);
    xfer(1, 8'h48, 32'h0);
    xfer(0, 8'h48, 32'h0);
    `CHK(q, 32'h0003_0000)
    xfer(1, 8'h58, 32'hAA37);
    xfer(1, 8'h48, 32'h0);
    xfer(0, 8'h48, 32'h0);
    `CHK(q, 32'h0)
    xfer(1, 8'h44, 32'h0003_0000);
  endtask
  task automatic t_remote(input bit cs);
    xfer(1, 8'h4C, cs ? 32'h2 : 32'h0);
    host.line(1'b1, 1'b0);
    repeat (40) @(posedge CLK);
    xfer(1, 8'h50, 32'h1);
    xfer(1, 8'h50, 32'h0);
    for (n = 0; SUSPEND !== 1'b1 && n < 20; n++) @(posedge CLK);
    `CHK(SUSPEND, 1'b1)
    VBUS <= cs;
    CS_N <= !cs;
    WAKEUP <= !cs;
    for (n = 0; SUSPEND !== 1'b0 && n < 60; n++) @(posedge CLK);
    repeat (2) @(posedge CLK);
    `CHK(DRIVE_K, 1'b1)
    repeat (30) @(posedge CLK);
    `CHK(DRIVE_K, 1'b0)
    WAKEUP <= 1'b0;
    CS_N <= 1'b1;
    host.line(1'b0, 1'b0);
    xfer(1, 8'h58, 32'hAA37);
    xfer(1, 8'h44, 32'h0003_0000);
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    close_out();
  end
  initial begin
    RESETN = 1'b0;
    AVS_ADDRESS = 8'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    WAKEUP = 1'b0;
    CS_N = 1'b1;
    VBUS = 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    t_alloc();
    t_events();
    t_setup();
    t_suspend();
    t_remote(1'b0);
    t_remote(1'b1);
    close_out();
  end
endmodule
`default_nettype wire
